// ==== src/flash_partition_sequencer.sv ====
// Flash command sequencer with partition command and write-once clock divider
//
// Notes on behaviour
// R1: Partition launched when partitions already exist sets access error, no repartition.
// R2: Partition launch with command index not 010 sets access error.
// R3: Partition launch during active load-data sequence sets access error.
// R4: Partition launch in a mode that forbids it sets access error.
// R5: Out-of-range direct or emulation partition size sets access error.
// R6: Internal read error sets status bit 1; uncorrectable sets status bit 0.
// R7: Command complete flag sets when the partition operation finishes.
// R8: Partition sizes count 256-byte sectors, direct and emulation separately.
// R9: Partition stores size, duplicate, emulation size, duplicate in info words.
// R10: Divider loaded bit reads 1 after a divider write since reset.
// R11: Lower seven divider bits write once; loaded bit read-only; all readable.
// R12: Software picks divider giving roughly 1 MHz flash clock.
// R13: Software should not write divider while a command runs.
// R14: Divider writes are accepted during post-reset initialisation.
// R15: Read-once command completes within 400 bus clocks.
// R16: Load-data command completes within 450 bus clocks.
// R17: Program phrase takes 130+14n flash ticks plus 2125+510n bus clocks.
// R18: Program-once takes 162 flash ticks plus 2400 bus clocks.
// R19: Emulation disable completes within 300 bus clocks.
// R20: Emulation query completes within 300 bus clocks.
// R21: Partition takes 21800 flash ticks plus 400000 bus clocks at most.
// R22: Separate bus-clock and flash-tick counters bound each command phase.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
`include "flash_seq_map.svh"

module flash_partition_sequencer #(
    parameter int unsigned PART_BUS_CYCLES = `PART_BUS_CYCLES,
    parameter int unsigned DF_SECTORS      = `DF_SECTORS_MAX,
    parameter int unsigned ER_SECTORS      = `ER_SECTORS_MAX
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic        mode_allowed,
    input  wire logic        read_error,
    input  wire logic        read_uncorrectable,
    output logic [15:0]      rd_data,
    output logic             command_complete,
    output logic             access_error
);

    // ****************************************
    // State
    // ****************************************
    flash_seq_pkg::seq_state_e     state_r, state_nxt;
    flash_seq_pkg::flash_status_s  stat_r, stat_nxt;
    flash_seq_pkg::clock_divider_s div_r, div_nxt;
    logic [2:0]                    idx_r, idx_nxt;
    logic [15:0]                   ccob_r [8];
    logic [15:0]                   ccob_nxt [8];
    logic [15:0]                   info_r [4];
    logic [15:0]                   info_nxt [4];
    logic [18:0]                   bus_cnt_r, bus_cnt_nxt;
    logic [14:0]                   flash_timing_clock_cnt_r, flash_timing_clock_cnt_nxt;
    logic [7:0]                    cmd_r, cmd_nxt;
    logic                          multi_block_load_r, multi_block_load_nxt;
    logic [1:0]                    ndload_r, ndload_nxt;
    logic                          parted_r, parted_nxt;
    logic [5:0]                    init_cnt_r, init_cnt_nxt;
    logic [15:0]                   rd_data_r, rd_data_nxt;
    logic [2:0]                    sync1_r, sync2_r;
    logic                          tick;
    logic                          cmd_err;
    logic                          known_cmd;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= {mode_allowed, read_error, read_uncorrectable};
            sync2_r <= sync1_r;
        end
    end

    // ****************************************
    // Flash timing clock
    // ****************************************
    flash_tick_gen u_tick (
        .mclk          (mclk),
        .rst           (rst),
        .enable        (div_r.loaded),
        .divider_value (div_r.value),
        .tick          (tick)
    );

    // ****************************************
    // Command durations
    // ****************************************
    function automatic logic [18:0] bus_cycles(input logic [7:0] cmd, input logic [1:0] n);
        logic [18:0] c;
        c = 19'h0;
        case (cmd)
            // R15: read-once bound
            `CMD_READ_ONCE:    c = 19'(`READ_ONCE_BUS);
            // R16: load-data bound
            `CMD_LOAD_DATA:    c = 19'(`LOAD_DATA_BUS);
            // R17: program bus part
            `CMD_PROGRAM:      c = 19'(`PROGRAM_BUS) + 19'(`PROGRAM_BUS_EXTRA) * 19'(n);
            // R18: program-once bus part
            `CMD_PROGRAM_ONCE: c = 19'(`PROG_ONCE_BUS);
            // R19: disable bound
            `CMD_EEE_DISABLE:  c = 19'(`EEE_DISABLE_BUS);
            // R20: query bound
            `CMD_EEE_QUERY:    c = 19'(`EEE_QUERY_BUS);
            // R21: partition bus part
            `CMD_PARTITION:    c = 19'(PART_BUS_CYCLES);
            default:           c = 19'h0;
        endcase
        bus_cycles = c - 19'(`SEQ_OVERHEAD);
    endfunction

    function automatic logic [14:0] flash_timing_clock_ticks(input logic [7:0] cmd, input logic [1:0] n);
        logic [14:0] t;
        t = 15'h0;
        case (cmd)
            // R17: program flash part
            `CMD_PROGRAM:      t = 15'(`PROGRAM_FLASH_TIMING_CLOCK) + 15'(`PROGRAM_FLASH_TIMING_CLOCK_EXTRA) * 15'(n);
            // R18: program-once flash part
            `CMD_PROGRAM_ONCE: t = 15'(`PROG_ONCE_FLASH_TIMING_CLOCK);
            // R21: partition flash part
            `CMD_PARTITION:    t = 15'(`PART_FLASH_TIMING_CLOCK);
            default:           t = 15'h0;
        endcase
        flash_timing_clock_ticks = t;
    endfunction

    // ****************************************
    // Launch checks
    // ****************************************
    always_comb begin
        known_cmd = 1'b0;
        case (cmd_r)
            `CMD_READ_ONCE, `CMD_LOAD_DATA, `CMD_PROGRAM, `CMD_PROGRAM_ONCE,
            `CMD_EEE_DISABLE, `CMD_EEE_QUERY, `CMD_PARTITION: known_cmd = 1'b1;
            default: known_cmd = 1'b0;
        endcase
        cmd_err = !known_cmd || !div_r.loaded;
        if (cmd_r == `CMD_PARTITION) begin
            // R2: index check
            if (idx_r != `PART_INDEX) begin
                cmd_err = 1'b1;
            end
            // R3: load sequence active
            if (multi_block_load_r) begin
                cmd_err = 1'b1;
            end
            // R4: mode not allowed
            if (!sync2_r[2]) begin
                cmd_err = 1'b1;
            end
            // R1: already partitioned
            if (parted_r) begin
                cmd_err = 1'b1;
            end
            // R5 R8: sector count range
            if (32'(ccob_r[1]) > DF_SECTORS || 32'(ccob_r[2]) > ER_SECTORS) begin
                cmd_err = 1'b1;
            end
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_nxt    = state_r;
        stat_nxt     = stat_r;
        div_nxt      = div_r;
        idx_nxt      = idx_r;
        ccob_nxt     = ccob_r;
        info_nxt     = info_r;
        bus_cnt_nxt  = bus_cnt_r;
        flash_timing_clock_cnt_nxt = flash_timing_clock_cnt_r;
        cmd_nxt      = cmd_r;
        multi_block_load_nxt    = multi_block_load_r;
        ndload_nxt   = ndload_r;
        parted_nxt   = parted_r;
        init_cnt_nxt = init_cnt_r;
        rd_data_nxt  = 16'h0000;

        if (wr_en) begin
            case (addr)
                `OFS_CLOCK_DIVIDER: begin
                    // R11 R14: write once, also during init
                    if (!div_r.loaded) begin
                        div_nxt.value  = wr_data[6:0];
                        // R10: mark loaded
                        div_nxt.loaded = 1'b1;
                    end
                end
                `OFS_CMD_INDEX: begin
                    if (stat_r.command_complete_flag) begin
                        idx_nxt = wr_data[2:0];
                    end
                end
                `OFS_CMD_WORD: begin
                    if (stat_r.command_complete_flag) begin
                        ccob_nxt[idx_r] = wr_data;
                    end
                end
                `OFS_STATUS: begin
                    if (wr_data[`STAT_ACCESS_ERROR_FLAG_BIT]) begin
                        stat_nxt.access_error_flag = 1'b0;
                    end
                    if (wr_data[`STAT_COMMAND_COMPLETE_FLAG_BIT] && stat_r.command_complete_flag && !stat_r.access_error_flag && state_r == flash_seq_pkg::ST_IDLE) begin
                        stat_nxt.command_complete_flag    = 1'b0;
                        stat_nxt.memctl_error_status_hi = 1'b0;
                        stat_nxt.memctl_uncorrectable_status = 1'b0;
                        cmd_nxt          = ccob_r[0][15:8];
                        state_nxt        = flash_seq_pkg::ST_CHECK;
                    end
                end
                default: begin
                end
            endcase
        end

        case (state_r)
            flash_seq_pkg::ST_INIT: begin
                init_cnt_nxt = init_cnt_r - 6'h01;
                if (init_cnt_r == 6'h00) begin
                    stat_nxt.command_complete_flag = 1'b1;
                    state_nxt     = flash_seq_pkg::ST_IDLE;
                end
            end
            flash_seq_pkg::ST_IDLE: begin
            end
            flash_seq_pkg::ST_CHECK: begin
                if (cmd_err) begin
                    // R1 R2 R3 R4 R5: access error, no action
                    stat_nxt.access_error_flag = 1'b1;
                    stat_nxt.command_complete_flag   = 1'b1;
                    state_nxt       = flash_seq_pkg::ST_IDLE;
                end else begin
                    // R22: load both phase counters
                    bus_cnt_nxt  = bus_cycles(cmd_r, ndload_r);
                    flash_timing_clock_cnt_nxt = flash_timing_clock_ticks(cmd_r, ndload_r);
                    state_nxt    = flash_seq_pkg::ST_FLASH_TIMING_CLOCK;
                end
            end
            flash_seq_pkg::ST_FLASH_TIMING_CLOCK: begin
                // R6: internal read status
                if (cmd_r == `CMD_PARTITION) begin
                    stat_nxt.memctl_error_status_hi = stat_r.memctl_error_status_hi | sync2_r[1];
                    stat_nxt.memctl_uncorrectable_status = stat_r.memctl_uncorrectable_status | sync2_r[0];
                end
                // R22: flash tick counter
                if (flash_timing_clock_cnt_r == 15'h0) begin
                    state_nxt = flash_seq_pkg::ST_BUS;
                end else if (tick) begin
                    flash_timing_clock_cnt_nxt = flash_timing_clock_cnt_r - 15'h1;
                end
            end
            flash_seq_pkg::ST_BUS: begin
                // R22: bus cycle counter
                bus_cnt_nxt = bus_cnt_r - 19'h1;
                if (bus_cnt_r == 19'h0) begin
                    state_nxt = flash_seq_pkg::ST_DONE;
                end
            end
            flash_seq_pkg::ST_DONE: begin
                case (cmd_r)
                    `CMD_LOAD_DATA: begin
                        multi_block_load_nxt = 1'b1;
                        if (multi_block_load_r && ndload_r != 2'h3) begin
                            ndload_nxt = ndload_r + 2'h1;
                        end
                    end
                    `CMD_PROGRAM: begin
                        multi_block_load_nxt  = 1'b0;
                        ndload_nxt = 2'h0;
                    end
                    `CMD_PARTITION: begin
                        // R9: store sizes and duplicates
                        info_nxt[0] = ccob_r[1];
                        info_nxt[1] = ccob_r[1];
                        info_nxt[2] = ccob_r[2];
                        info_nxt[3] = ccob_r[2];
                        parted_nxt  = 1'b1;
                    end
                    default: begin
                    end
                endcase
                // R7: command complete
                stat_nxt.command_complete_flag = 1'b1;
                state_nxt     = flash_seq_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = flash_seq_pkg::ST_IDLE;
            end
        endcase

        if (rd_en) begin
            case (addr)
                // R11: all eight bits readable
                `OFS_CLOCK_DIVIDER: rd_data_nxt = {8'h00, div_r.loaded, div_r.value};
                `OFS_CMD_INDEX:     rd_data_nxt = {13'h0000, idx_r};
                `OFS_CMD_WORD:      rd_data_nxt = ccob_r[idx_r];
                `OFS_STATUS: begin
                    rd_data_nxt[`STAT_COMMAND_COMPLETE_FLAG_BIT]    = stat_r.command_complete_flag;
                    rd_data_nxt[`STAT_ACCESS_ERROR_FLAG_BIT]  = stat_r.access_error_flag;
                    rd_data_nxt[`STAT_MEMCTL_ERROR_STATUS_HI_BIT] = stat_r.memctl_error_status_hi;
                    rd_data_nxt[`STAT_MEMCTL_UNCORRECTABLE_STATUS_BIT] = stat_r.memctl_uncorrectable_status;
                end
                `OFS_ERROR_STATUS:  rd_data_nxt = 16'h0000;
                default: begin
                    if (addr[3]) begin
                        rd_data_nxt = info_r[addr[1:0]];
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r    <= flash_seq_pkg::ST_INIT;
            stat_r     <= '0;
            div_r      <= '{value: `DIV_RESET, loaded: 1'b0};
            idx_r      <= 3'h0;
            ccob_r     <= '{default: 16'h0000};
            info_r     <= '{default: 16'hffff};
            bus_cnt_r  <= 19'h0;
            flash_timing_clock_cnt_r <= 15'h0;
            cmd_r      <= 8'h00;
            multi_block_load_r    <= 1'b0;
            ndload_r   <= 2'h0;
            parted_r   <= 1'b0;
            init_cnt_r <= 6'(`INIT_CYCLES - 1);
            rd_data_r  <= 16'h0000;
        end else begin
            state_r    <= state_nxt;
            stat_r     <= stat_nxt;
            div_r      <= div_nxt;
            idx_r      <= idx_nxt;
            ccob_r     <= ccob_nxt;
            info_r     <= info_nxt;
            bus_cnt_r  <= bus_cnt_nxt;
            flash_timing_clock_cnt_r <= flash_timing_clock_cnt_nxt;
            cmd_r      <= cmd_nxt;
            multi_block_load_r    <= multi_block_load_nxt;
            ndload_r   <= ndload_nxt;
            parted_r   <= parted_nxt;
            init_cnt_r <= init_cnt_nxt;
            rd_data_r  <= rd_data_nxt;
        end
    end

    assign rd_data          = rd_data_r;
    assign command_complete = stat_r.command_complete_flag;
    assign access_error     = stat_r.access_error_flag;

endmodule

// ==== src/flash_seq_map.svh ====
// Offsets, field positions, command codes and timing counts of the flash sequencer
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

// ****************************************
// Register offsets (word index)
// ****************************************
`define OFS_CLOCK_DIVIDER   4'h0
`define OFS_CMD_INDEX       4'h1
`define OFS_CMD_WORD        4'h2
`define OFS_STATUS          4'h3
`define OFS_ERROR_STATUS    4'h4
`define OFS_INFO_BASE       4'h8

// ****************************************
// Field positions and reset values
// ****************************************
`define DIV_LOADED_BIT      7
`define STAT_COMMAND_COMPLETE_FLAG_BIT       7
`define STAT_ACCESS_ERROR_FLAG_BIT     5
`define STAT_PROTECTION_VIOLATION_FLAG_BIT     4
`define STAT_MEMCTL_ERROR_STATUS_HI_BIT    1
`define STAT_MEMCTL_UNCORRECTABLE_STATUS_BIT    0
`define DIV_RESET           7'h00
`define PART_INDEX          3'h2

// ****************************************
// Command codes
// ****************************************
`define CMD_READ_ONCE       8'h04
`define CMD_LOAD_DATA       8'h05
`define CMD_PROGRAM         8'h06
`define CMD_PROGRAM_ONCE    8'h07
`define CMD_EEE_DISABLE     8'h14
`define CMD_EEE_QUERY       8'h15
`define CMD_PARTITION       8'h20

// ****************************************
// Information word global addresses
// ****************************************
`define INFO_ADDR_DF        24'h120000
`define INFO_ADDR_DF_DUP    24'h120002
`define INFO_ADDR_ER        24'h120004
`define INFO_ADDR_ER_DUP    24'h120006

// ****************************************
// Timing counts (bus clock 100 MHz, flash clock ticks)
// ****************************************
`define BUS_FREQ_MHZ        100
`define SECTOR_BYTES        256
`define DF_SECTORS_MAX      128
`define ER_SECTORS_MAX      16
`define INIT_CYCLES         32
`define SEQ_OVERHEAD        4
`define READ_ONCE_BUS       400
`define LOAD_DATA_BUS       450
`define PROGRAM_FLASH_TIMING_CLOCK        130
`define PROGRAM_FLASH_TIMING_CLOCK_EXTRA  14
`define PROGRAM_BUS         2125
`define PROGRAM_BUS_EXTRA   510
`define PROG_ONCE_FLASH_TIMING_CLOCK      162
`define PROG_ONCE_BUS       2400
`define EEE_DISABLE_BUS     300
`define EEE_QUERY_BUS       300
`define PART_FLASH_TIMING_CLOCK           21800
`define PART_BUS_CYCLES     400000

`endif

// ==== src/flash_seq_pkg.sv ====
// Types shared by the flash sequencer files
package flash_seq_pkg;

    typedef enum logic [5:0] {
        ST_INIT  = 6'b000001,
        ST_IDLE  = 6'b000010,
        ST_CHECK = 6'b000100,
        ST_FLASH_TIMING_CLOCK  = 6'b001000,
        ST_BUS   = 6'b010000,
        ST_DONE  = 6'b100000
    } seq_state_e;

    typedef struct packed {
        logic command_complete_flag;
        logic access_error_flag;
        logic memctl_error_status_hi;
        logic memctl_uncorrectable_status;
    } flash_status_s;

    typedef struct packed {
        logic [6:0] value;
        logic       loaded;
    } clock_divider_s;

endpackage

// ==== src/flash_tick_gen.sv ====
// Flash timing clock tick generator dividing the bus clock
`timescale 1ns/10ps
`include "flash_seq_map.svh"

module flash_tick_gen (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic [6:0] divider_value,
    output logic            tick
);

    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic       tick_r;
    logic       tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!enable) begin
            cnt_nxt = 7'h00;
        end else if (cnt_r >= divider_value) begin
            cnt_nxt  = 7'h00;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 7'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r  <= 7'h00;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule

// ==== verification/flash_partition_and_command_timing_tb.sv ====
// Self-checking bench for the flash partition sequencer
`timescale 1ns/10ps
`include "flash_seq_map.svh"

module flash_partition_and_command_timing_tb;
    localparam int PB = 50;
    logic        mclk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic        mode_allowed = 1'b1, read_error = 1'b0, read_uncorrectable = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wr_data = 16'h0000;
    logic [15:0] rd_data, d;
    logic        command_complete, access_error;
    int          err_total = 0, comparisons = 0, cyc;

    always #5 mclk = ~mclk;

    flash_partition_sequencer #(.PART_BUS_CYCLES(PB)) DUT (
        .mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .mode_allowed(mode_allowed), .read_error(read_error), .read_uncorrectable(read_uncorrectable),
        .rd_data(rd_data), .command_complete(command_complete), .access_error(access_error));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr <= a; wr_data <= v; wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk);
        addr <= a; rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask

    task automatic cmd(input logic [7:0] code, input logic [2:0] idx, input logic [15:0] df, input logic [15:0] er);
        wr(`OFS_CMD_INDEX, 16'h0000); wr(`OFS_CMD_WORD, {code, 8'h00});
        wr(`OFS_CMD_INDEX, 16'h0001); wr(`OFS_CMD_WORD, df);
        wr(`OFS_CMD_INDEX, 16'h0002); wr(`OFS_CMD_WORD, er);
        wr(`OFS_CMD_INDEX, {13'h0000, idx});
        wr(`OFS_STATUS, 16'h0080);
        cyc = 0;
        while (cyc < 60000) begin
            @(posedge mclk);
            #1 cyc++;
            if (command_complete === 1'b1) break;
        end
        if (cyc >= 60000) begin
            err_total++;
            print_verdict();
        end
    endtask

    task automatic fail_cmd(input logic [7:0] code, input logic [2:0] idx, input logic [15:0] df, input logic [15:0] er);
        cmd(code, idx, df, er);
        check(cyc, 1);
        check(access_error, 1'b1);
        wr(`OFS_STATUS, 16'h0020);
        rd(`OFS_STATUS, d);
        check(d[5], 1'b0);
    endtask

    task automatic ok_cmd(input logic [7:0] code, input int bound);
        cmd(code, 3'h0, 16'h0000, 16'h0000);
        check(cyc <= bound, 1);
        check(access_error, 1'b0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        #1 check(rd_data, 16'h0000);
        check(command_complete, 1'b0);
        rd(`OFS_CLOCK_DIVIDER, d); check(d, 16'h0000);
        wr(`OFS_CLOCK_DIVIDER, 16'h0001);
        rd(`OFS_CLOCK_DIVIDER, d); check(d, 16'h0081);
        wr(`OFS_CLOCK_DIVIDER, 16'h007f);
        rd(`OFS_CLOCK_DIVIDER, d); check(d, 16'h0081);
        cyc = 0;
        while (command_complete !== 1'b1 && cyc < 100) begin
            @(posedge mclk);
            #1 cyc++;
        end
        check(command_complete, 1'b1);
        if (command_complete !== 1'b1) print_verdict();
        rd(4'h5, d); check(d, 16'h0000);
        rd(`OFS_ERROR_STATUS, d); check(d, 16'h0000);
        rd(`OFS_INFO_BASE, d); check(d, 16'hffff);
        fail_cmd(`CMD_PARTITION, 3'h3, 16'h0000, 16'h0010);
        mode_allowed <= 1'b0;
        repeat (4) @(posedge mclk);
        fail_cmd(`CMD_PARTITION, 3'h2, 16'h0000, 16'h0010);
        mode_allowed <= 1'b1;
        repeat (4) @(posedge mclk);
        fail_cmd(`CMD_PARTITION, 3'h2, 16'h0081, 16'h0010);
        fail_cmd(`CMD_PARTITION, 3'h2, 16'h0000, 16'h0011);
        ok_cmd(`CMD_LOAD_DATA, 450);
        fail_cmd(`CMD_PARTITION, 3'h2, 16'h0000, 16'h0010);
        ok_cmd(`CMD_PROGRAM, 130 * 2 + 2125);
        read_error <= 1'b1;
        repeat (4) @(posedge mclk);
        cmd(`CMD_PARTITION, 3'h2, 16'h0000, 16'h0010);
        check(cyc <= 21800 * 2 + PB, 1);
        check(access_error, 1'b0);
        read_error <= 1'b0;
        rd(`OFS_STATUS, d); check(d[1:0], 2'b10);
        rd(4'h8, d); check(d, 16'h0000);
        rd(4'h9, d); check(d, 16'h0000);
        rd(4'ha, d); check(d, 16'h0010);
        rd(4'hb, d); check(d, 16'h0010);
        fail_cmd(`CMD_PARTITION, 3'h2, 16'h0004, 16'h0008);
        rd(4'ha, d); check(d, 16'h0010);
        ok_cmd(`CMD_READ_ONCE, 400);
        ok_cmd(`CMD_EEE_QUERY, 300);
        ok_cmd(`CMD_EEE_DISABLE, 300);
        ok_cmd(`CMD_PROGRAM_ONCE, 162 * 2 + 2400);
        rd(`OFS_STATUS, d); check(d[1:0], 2'b00);
        print_verdict();
    end
endmodule

// ==== verification/flash_seq_checker.sv ====
// Port-level assertions for the flash partition sequencer
`timescale 1ns/10ps
`include "flash_seq_map.svh"

module flash_seq_checker #(
    parameter int unsigned PART_BUS_CYCLES = `PART_BUS_CYCLES,
    parameter int unsigned DF_SECTORS      = `DF_SECTORS_MAX,
    parameter int unsigned ER_SECTORS      = `ER_SECTORS_MAX
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic        mode_allowed,
    input wire logic        read_error,
    input wire logic        read_uncorrectable,
    input wire logic [15:0] rd_data,
    input wire logic        command_complete,
    input wire logic        access_error
);
    // ****************************************
    // Divider shadow
    // ****************************************
    logic       seen_r;
    logic [6:0] held_r;
    logic       stat_wr;
    assign stat_wr = wr_en && (addr == `OFS_STATUS);

    always_ff @(posedge mclk) begin
        if (rst) begin
            seen_r <= 1'b0;
            held_r <= 7'h00;
        end else if (wr_en && (addr == `OFS_CLOCK_DIVIDER) && !seen_r) begin
            seen_r <= 1'b1;
            held_r <= wr_data[6:0];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_reset_quiet: assert property (disable iff (1'b0) rst |=> (rd_data == 16'h0000) && !command_complete && !access_error)
        else $error("outputs not quiet after reset");
    a_read_idle: assert property (!rd_en |=> rd_data == 16'h0000)
        else $error("read data not zero outside read answer");
    a_div_readback: assert property (rd_en && (addr == `OFS_CLOCK_DIVIDER) |=> rd_data[7:0] == {seen_r, held_r})
        else $error("divider readback wrong");
    a_errstat_zero: assert property (rd_en && (addr == `OFS_ERROR_STATUS) |=> rd_data == 16'h0000)
        else $error("error status not zero");
    a_protection_violation_flag_zero: assert property (rd_en && (addr == `OFS_STATUS) |=> !rd_data[4])
        else $error("protection bit set");
    a_launch_fall: assert property (stat_wr && wr_data[7] && command_complete && !access_error |=> !command_complete)
        else $error("complete did not fall on launch");
    a_cc_hold: assert property (command_complete && !(stat_wr && wr_data[7]) |=> command_complete)
        else $error("complete dropped without launch");
    a_err_with_cc: assert property ($rose(access_error) |-> $rose(command_complete))
        else $error("access error rose without completion");
    a_err_hold: assert property (access_error && !(stat_wr && wr_data[5]) |=> access_error)
        else $error("access error dropped without clear");
    a_err_clear: assert property (access_error && stat_wr && wr_data[5] && !wr_data[7] |=> !access_error)
        else $error("access error not cleared");
endmodule

bind flash_partition_sequencer flash_seq_checker #(
    .PART_BUS_CYCLES(PART_BUS_CYCLES), .DF_SECTORS(DF_SECTORS), .ER_SECTORS(ER_SECTORS)
) chk (
    .mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .mode_allowed(mode_allowed), .read_error(read_error), .read_uncorrectable(read_uncorrectable),
    .rd_data(rd_data), .command_complete(command_complete), .access_error(access_error)
);
